//--- common/asa_pkg.sv
package asa_pkg;

    // Host clock
    localparam int CLK_PERIOD_NS = 100;

    // Least time in ns to whole clock cycles, never below one
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Memory timing figures
    localparam int POWERUP_WAIT_US = 100;
    localparam int READ_ACCESS_NS = 10;
    localparam int OUT_DRV_ACCESS_NS = 5;
    localparam int OUT_RELEASE_NS = 5;
    localparam int WRITE_PULSE_NS = 7;
    localparam int WRITE_DATA_SETUP_NS = 6;
    localparam int WRITE_TO_HIGHZ_DELAY_NS = 5;
    localparam int CYCLE_TIME_NS = 10;
    localparam int DESELECT_TO_RETENTION_NS = 0;

    // Derived cycle counts
    localparam int POWERUP_WAIT_CYCLES = cyc_min(POWERUP_WAIT_US * 1000);
    localparam int RD_ACCESS_CYCLES = cyc_min(READ_ACCESS_NS > OUT_DRV_ACCESS_NS ?
        READ_ACCESS_NS : OUT_DRV_ACCESS_NS);
    localparam int WR_PULSE_CYCLES = cyc_min(WRITE_PULSE_NS > WRITE_DATA_SETUP_NS ?
        WRITE_PULSE_NS : WRITE_DATA_SETUP_NS);
    localparam int GAP_CYCLES = cyc_min(CYCLE_TIME_NS > OUT_RELEASE_NS ?
        CYCLE_TIME_NS : OUT_RELEASE_NS);
    localparam int RETAIN_CYCLES = cyc_min(DESELECT_TO_RETENTION_NS);

    // Pin input synchroniser depth
    localparam int SYNC_STAGES = 3;
    localparam int RD_WAIT_CYCLES = RD_ACCESS_CYCLES + SYNC_STAGES;

    localparam int CNT_W = $clog2(POWERUP_WAIT_CYCLES + 1);

    // Widths
    localparam int ADDR_W = 17;
    localparam int DATA_W = 8;

    typedef enum logic [8:0] {
        ST_POWERUP = 9'h001,
        ST_IDLE = 9'h002,
        ST_WR_SETUP = 9'h004,
        ST_WR_PULSE = 9'h008,
        ST_WR_END = 9'h010,
        ST_RD_WAIT = 9'h020,
        ST_GAP = 9'h040,
        ST_RETAIN = 9'h080,
        ST_RET_EXIT = 9'h100
    } asa_state_t;

endpackage

//--- common/asa_sync_if.sv
`timescale 1ns/1ps
interface asa_sync_if #(parameter int W = 8) ();
    logic [W-1:0] raw;
    logic [W-1:0] settled;
    logic agree;
    modport filter (input raw, output settled, output agree);
    modport user (output raw, input settled, input agree);
endinterface

//--- verilog/asa_pin_sync.sv
`timescale 1ns/1ps
module asa_pin_sync #(
    parameter int W = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    asa_sync_if.filter port
);

    logic [W-1:0] eq;
    logic agree;
    logic next_agree;

    // Three stages per bit; a change counts once stages two and three agree
    for (genvar i = 0; i < W; i++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        logic held;
        logic next_held;

        always_comb begin
            next_held = held;
            if (s2 == s3) begin
                next_held = s3;
            end
        end

        always_ff @(posedge clk_in or posedge reset_in) begin
            if (reset_in) begin
                s1 <= 1'b0;
                s2 <= 1'b0;
                s3 <= 1'b0;
                held <= 1'b0;
            end else begin
                s1 <= port.raw[i];
                s2 <= s1;
                s3 <= s2;
                held <= next_held;
            end
        end

        assign eq[i] = (s2 == s3);
        assign port.settled[i] = held;
    end

    always_comb begin
        next_agree = &eq;
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            agree <= 1'b0;
        end else begin
            agree <= next_agree;
        end
    end

    assign port.agree = agree;

    // Settled value only moves after the later stages agreed
    settle_on_agree_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $changed(port.settled) |-> $past(eq) != '0)
        else $error("settled data moved while no bit agreed");

endmodule

//--- verilog/asa_host.sv
`timescale 1ns/1ps
// Behaviour
// - No access until supply has been steady 100 us after power-up.
// - Address stable at least 7 ns before the write-ending edge.
// - Address may change at write end, stable by write start.
// - Write data stable at least 6 ns before the write-ending edge.
// - Write data may be removed at the write-ending edge.
// - Write data timed against whichever strobe ends the write.
// - Strobe-controlled write with output drive low lasts float plus setup.
// - Host never drives data pins while the memory drives them.
// - Address valid no later than select falling on a read.
// - Write strobe held high for the whole of every read.
// - Deselect the chip before the supply drops to retention.
module asa_host #(
    parameter int ADDR_W = asa_pkg::ADDR_W,
    parameter int DATA_W = asa_pkg::DATA_W
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [ADDR_W-1:0] req_addr_in,
    input wire logic [DATA_W-1:0] req_wdata_in,
    output logic req_ready_out,
    output logic [DATA_W-1:0] rdata_out,
    output logic rdata_valid_out,
    input wire logic retention_req_in,
    output logic retention_ok_out,
    output logic [ADDR_W-1:0] address_pins_out,
    output logic chip_sel_n_out,
    output logic wr_strobe_n_out,
    output logic out_drv_n_out,
    input wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output logic data_pins_oe_out
);

    localparam int CW = asa_pkg::CNT_W;
    localparam int RD_LO = 5;
    localparam int RD_HI = 40;

    asa_pkg::asa_state_t state;
    asa_pkg::asa_state_t next_state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [ADDR_W-1:0] addr;
    logic [ADDR_W-1:0] next_addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] next_wdata;
    logic cs_n;
    logic next_cs_n;
    logic we_n;
    logic next_we_n;
    logic oe_n;
    logic next_oe_n;
    logic doe;
    logic next_doe;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;
    logic rvalid;
    logic next_rvalid;
    logic ret_ok;
    logic next_ret_ok;
    logic take;

    asa_sync_if #(.W(DATA_W)) sync_bus ();

    assign sync_bus.raw = data_pins_in;

    // Read data passes the pin synchroniser before capture
    asa_pin_sync #(.W(DATA_W)) u_sync (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .port(sync_bus.filter)
    );

    // Retention request blocks new cycles so the chip can be deselected
    assign take = (state == asa_pkg::ST_IDLE) && req_valid_in && !retention_req_in;
    assign req_ready_out = (state == asa_pkg::ST_IDLE) && !retention_req_in;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_addr = addr;
        next_wdata = wdata;
        next_cs_n = cs_n;
        next_we_n = we_n;
        next_oe_n = oe_n;
        next_doe = doe;
        next_rdata = rdata;
        next_rvalid = 1'b0;
        next_ret_ok = 1'b0;
        case (state)
            asa_pkg::ST_POWERUP: begin
                if (cnt == '0) begin
                    next_state = asa_pkg::ST_IDLE;
                end else begin
                    next_cnt = cnt - CW'(1);
                end
            end
            asa_pkg::ST_IDLE: begin
                if (retention_req_in) begin
                    next_state = asa_pkg::ST_RETAIN;
                    next_cnt = CW'(asa_pkg::RETAIN_CYCLES - 1);
                end else if (take) begin
                    next_addr = req_addr_in;
                    next_cs_n = 1'b0;
                    if (req_write_in) begin
                        next_wdata = req_wdata_in;
                        next_doe = 1'b1;
                        next_oe_n = 1'b1;
                        next_state = asa_pkg::ST_WR_SETUP;
                    end else begin
                        next_oe_n = 1'b0;
                        next_we_n = 1'b1;
                        next_cnt = CW'(asa_pkg::RD_WAIT_CYCLES);
                        next_state = asa_pkg::ST_RD_WAIT;
                    end
                end
            end
            asa_pkg::ST_WR_SETUP: begin
                next_we_n = 1'b0;
                next_cnt = CW'(asa_pkg::WR_PULSE_CYCLES - 1);
                next_state = asa_pkg::ST_WR_PULSE;
            end
            asa_pkg::ST_WR_PULSE: begin
                if (cnt == '0) begin
                    next_we_n = 1'b1;
                    next_state = asa_pkg::ST_WR_END;
                end else begin
                    next_cnt = cnt - CW'(1);
                end
            end
            asa_pkg::ST_WR_END: begin
                // select rises a cycle after the strobe
                next_cs_n = 1'b1;
                // data released after the ending edge
                next_doe = 1'b0;
                next_cnt = CW'(asa_pkg::GAP_CYCLES - 1);
                next_state = asa_pkg::ST_GAP;
            end
            asa_pkg::ST_RD_WAIT: begin
                // waits out access plus synchroniser depth
                if (cnt != '0) begin
                    next_cnt = cnt - CW'(1);
                end else if (sync_bus.agree) begin
                    next_rdata = sync_bus.settled;
                    next_rvalid = 1'b1;
                    next_cs_n = 1'b1;
                    next_oe_n = 1'b1;
                    next_cnt = CW'(asa_pkg::GAP_CYCLES - 1);
                    next_state = asa_pkg::ST_GAP;
                end
            end
            asa_pkg::ST_GAP: begin
                if (cnt == '0) begin
                    next_state = asa_pkg::ST_IDLE;
                end else begin
                    next_cnt = cnt - CW'(1);
                end
            end
            asa_pkg::ST_RETAIN: begin
                if (cnt != '0) begin
                    next_cnt = cnt - CW'(1);
                end else begin
                    next_ret_ok = retention_req_in;
                end
                if (!retention_req_in) begin
                    next_cnt = CW'(asa_pkg::GAP_CYCLES - 1);
                    next_state = asa_pkg::ST_RET_EXIT;
                end
            end
            // Recovery of one cycle time after the supply returns
            asa_pkg::ST_RET_EXIT: begin
                if (cnt == '0) begin
                    next_state = asa_pkg::ST_IDLE;
                end else begin
                    next_cnt = cnt - CW'(1);
                end
            end
            default: begin
                next_state = asa_pkg::ST_IDLE;
                next_cs_n = 1'b1;
                next_we_n = 1'b1;
                next_oe_n = 1'b1;
                next_doe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state <= asa_pkg::ST_POWERUP;
            cnt <= CW'(asa_pkg::POWERUP_WAIT_CYCLES - 1);
            addr <= '0;
            wdata <= '0;
            cs_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            doe <= 1'b0;
            rdata <= '0;
            rvalid <= 1'b0;
            ret_ok <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            addr <= next_addr;
            wdata <= next_wdata;
            cs_n <= next_cs_n;
            we_n <= next_we_n;
            oe_n <= next_oe_n;
            doe <= next_doe;
            rdata <= next_rdata;
            rvalid <= next_rvalid;
            ret_ok <= next_ret_ok;
        end
    end

    assign address_pins_out = addr;
    assign chip_sel_n_out = cs_n;
    assign wr_strobe_n_out = we_n;
    assign out_drv_n_out = oe_n;
    assign data_pins_out = wdata;
    assign data_pins_oe_out = doe;
    assign rdata_out = rdata;
    assign rdata_valid_out = rvalid;
    assign retention_ok_out = ret_ok;

    // Cycles since reset, saturating; only the checks read it
    logic [CW-1:0] age;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            age <= '0;
        end else if (age != CW'(asa_pkg::POWERUP_WAIT_CYCLES)) begin
            age <= age + CW'(1);
        end
    end

    sequence wr_open_s;
        $fell(cs_n) && oe_n && we_n && doe;
    endsequence

    sequence wr_pulse_s;
        !we_n && !cs_n && doe && oe_n;
    endsequence

    sequence wr_close_s;
        we_n && !cs_n && doe;
    endsequence

    sequence rd_open_s;
        $fell(cs_n) && $fell(oe_n) && we_n && !doe;
    endsequence

    powerup_wait_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !cs_n |-> age == CW'(asa_pkg::POWERUP_WAIT_CYCLES))
        else $error("access before power-up wait ended");

    write_addr_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !we_n |-> $stable(addr) && !$past(cs_n))
        else $error("address moved while write strobe low");

    write_end_hold_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(we_n) |-> $stable(addr) && !cs_n)
        else $error("address or select moved at write end");

    write_data_setup_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !we_n |-> doe && $stable(wdata) && $past(doe))
        else $error("write data not stable before write end");

    write_sequence_a: assert property (@(posedge clk_in) disable iff (reset_in)
        wr_open_s |=> wr_pulse_s ##1 wr_close_s ##1 (cs_n && !doe))
        else $error("write strobe sequence broken");

    no_contention_a: assert property (@(posedge clk_in) disable iff (reset_in)
        doe |-> oe_n && $past(oe_n))
        else $error("data driven while memory output enabled");

    read_strobe_high_a: assert property (@(posedge clk_in) disable iff (reset_in)
        !oe_n |-> we_n && !doe && !cs_n)
        else $error("write strobe low during read");

    read_addr_valid_a: assert property (@(posedge clk_in) disable iff (reset_in)
        rd_open_s |-> addr == $past(req_addr_in) ##1 $stable(addr))
        else $error("read address not valid at select fall");

    read_return_a: assert property (@(posedge clk_in) disable iff (reset_in)
        rd_open_s |-> ##[RD_LO:RD_HI] rvalid)
        else $error("read data not returned in time");

    retention_deselect_a: assert property (@(posedge clk_in) disable iff (reset_in)
        ret_ok |-> cs_n && !doe && state == asa_pkg::ST_RETAIN)
        else $error("retention granted while selected");

    cycle_spacing_a: assert property (@(posedge clk_in) disable iff (reset_in)
        $rose(cs_n) |=> cs_n)
        else $error("select reasserted without a cycle gap");

endmodule

//--- verification/asa_sram_model.sv
`timescale 1ns/1ps
module asa_sram_model (
    input wire logic [16:0] address_pins_in,
    input wire logic chip_sel_n_in,
    input wire logic wr_strobe_n_in,
    input wire logic out_drv_n_in,
    input wire logic [7:0] data_pins_in,
    input wire logic slow_in,
    output logic [7:0] data_pins_out = 8'h5A,
    output logic data_pins_oe_out = 1'h0
);
    logic [7:0] mem [0:131071];
    logic writing;
    logic reading;

    assign writing = !chip_sel_n_in && !wr_strobe_n_in;
    assign reading = !chip_sel_n_in && !out_drv_n_in && wr_strobe_n_in;

    // store on the first strobe rise that ends the overlap
    always @(negedge writing) begin
        mem[address_pins_in] <= data_pins_in;
    end

    // old byte lingers, then garbage, then the new byte
    always @(address_pins_in or reading) begin
        data_pins_out <= #3 ~data_pins_out;
        if (reading) begin
            data_pins_out <= #(slow_in ? 10 : 4) mem[address_pins_in];
        end
    end

    // release the pins once select, drive or strobe drops it
    always @(reading) begin
        if (reading) begin
            data_pins_oe_out <= #3 1'h1;
        end else begin
            data_pins_oe_out <= #5 1'h0;
        end
    end
endmodule

//--- verification/async_sram_128kx8_access_test.sv
`timescale 1ns/1ps
module async_sram_128kx8_access_test;
    logic clk_in = 1'h0;
    logic reset_in = 1'h1;
    logic req_valid_in = 1'h0;
    logic req_write_in = 1'h0;
    logic [16:0] req_addr_in = 17'h00000;
    logic [7:0] req_wdata_in = 8'h00;
    logic retention_req_in = 1'h0;
    logic slow = 1'h0;
    wire logic req_ready_out, rdata_valid_out, retention_ok_out;
    wire logic chip_sel_n_out, wr_strobe_n_out, out_drv_n_out, data_pins_oe_out;
    wire logic [7:0] rdata_out, data_pins_out, mem_data;
    wire logic [16:0] address_pins_out;
    wire logic mem_oe;
    wire logic [7:0] pins;
    int err_count = 0;
    int cmp_count = 0;
    int up = 0;
    logic [31:0] seed = 32'hA569;
    logic [7:0] shadow [int];
    logic [7:0] q [$];
    logic [16:0] al [12];
    logic pwe = 1'h1;
    logic pcs = 1'h1;
    logic [16:0] pa = 17'h00000;
    logic [7:0] pd = 8'h00;
    logic poe = 1'h0;

    // Host wins the wire when enabled; a wire nobody drives shows the inverse
    assign pins = data_pins_oe_out ? data_pins_out : (mem_oe ? mem_data : ~mem_data);

    asa_host dut (.clk_in(clk_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
        .req_write_in(req_write_in), .req_addr_in(req_addr_in),
        .req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
        .rdata_out(rdata_out), .rdata_valid_out(rdata_valid_out),
        .retention_req_in(retention_req_in), .retention_ok_out(retention_ok_out),
        .address_pins_out(address_pins_out), .chip_sel_n_out(chip_sel_n_out),
        .wr_strobe_n_out(wr_strobe_n_out), .out_drv_n_out(out_drv_n_out),
        .data_pins_in(pins), .data_pins_out(data_pins_out),
        .data_pins_oe_out(data_pins_oe_out));

    asa_sram_model mem (.address_pins_in(address_pins_out), .chip_sel_n_in(chip_sel_n_out),
        .wr_strobe_n_in(wr_strobe_n_out), .out_drv_n_in(out_drv_n_out),
        .data_pins_in(pins), .slow_in(slow), .data_pins_out(mem_data),
        .data_pins_oe_out(mem_oe));

    initial begin
        forever #50 clk_in = ~clk_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Called at a falling edge; returns at the falling edge after the take
    task automatic req(input logic wr, input logic [16:0] a, input logic [7:0] d);
        int n;
        @(negedge clk_in);
        req_valid_in = 1'h1;
        req_write_in = wr;
        req_addr_in = a;
        req_wdata_in = d;
        n = 0;
        while (req_ready_out !== 1'h1 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        check1(n < 3000, 1'h1);
        if (wr) begin
            shadow[a] = d;
        end else begin
            q.push_back(shadow[a]);
        end
        @(negedge clk_in);
        req_valid_in = 1'h0;
    endtask

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            up <= 0;
        end else if (up < 5000) begin
            up <= up + 1;
        end
    end

    // Pin watcher and scoreboard, sampled where registered outputs are settled
    always @(negedge clk_in) begin
        if (!reset_in) begin
            // No select and no ready until the wait has run out
            if (up < asa_pkg::POWERUP_WAIT_CYCLES) begin
                check1(chip_sel_n_out & !req_ready_out, 1'h1);
            end
            check1(data_pins_oe_out & mem_oe, 1'h0);
            if (!wr_strobe_n_out) begin
                check1(out_drv_n_out, 1'h1);
            end
            if (!pwe || !wr_strobe_n_out) begin
                check1(address_pins_out == pa && data_pins_out == pd && poe, 1'h1);
            end
            if (!pcs && !chip_sel_n_out) begin
                check1(address_pins_out == pa, 1'h1);
            end
            if (!chip_sel_n_out && !out_drv_n_out) begin
                check1(wr_strobe_n_out, 1'h1);
            end
            if (retention_ok_out === 1'h1) begin
                check1(chip_sel_n_out, 1'h1);
            end
            if (rdata_valid_out === 1'h1) begin
                if (q.size() == 0) begin
                    check1(1'h0, 1'h1);
                end else begin
                    check8(rdata_out, q.pop_front());
                end
            end
        end
        pwe <= wr_strobe_n_out;
        pcs <= chip_sel_n_out;
        pa <= address_pins_out;
        pd <= data_pins_out;
        poe <= data_pins_oe_out;
    end

    initial begin
        repeat (12000) @(posedge clk_in);
        err_count++;
        end_sim();
    end

    initial begin
        int i;
        int n;
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        reset_in = 1'h0;
        for (i = 0; i < 12; i++) begin
            seed = xs(seed);
            slow = seed[31];
            al[i] = (i == 0) ? 17'h00000 : (i == 1) ? 17'h1FFFF : seed[16:0];
            req(1'h1, al[i], seed[24:17]);
        end
        for (i = 11; i >= 0; i--) begin
            seed = xs(seed);
            slow = seed[0];
            req(1'h0, al[i], 8'h00);
        end
        // Retention asked for with a write still in flight
        req(1'h1, al[3], 8'hC3);
        retention_req_in = 1'h1;
        n = 0;
        while (retention_ok_out !== 1'h1 && n < 20) begin
            @(negedge clk_in);
            n++;
        end
        check1(retention_ok_out, 1'h1);
        req_valid_in = 1'h1;
        req_write_in = 1'h0;
        req_addr_in = al[3];
        repeat (5) @(negedge clk_in);
        check1(req_ready_out, 1'h0);
        check1(chip_sel_n_out, 1'h1);
        retention_req_in = 1'h0;
        req(1'h0, al[3], 8'h00);
        // Reset landing in the middle of a read
        req(1'h0, al[1], 8'h00);
        reset_in = 1'h1;
        q.delete();
        @(negedge clk_in);
        check1(data_pins_oe_out, 1'h0);
        check1(chip_sel_n_out & wr_strobe_n_out & out_drv_n_out, 1'h1);
        reset_in = 1'h0;
        req(1'h0, al[0], 8'h00);
        req(1'h0, al[1], 8'h00);
        n = 0;
        while (q.size() != 0 && n < 50) begin
            @(negedge clk_in);
            n++;
        end
        check1(q.size() == 0, 1'h1);
        end_sim();
    end
endmodule
